// >>> logic/ccrb_bank.sv
// Clock configuration register bank: APB slave holding the clock unit's
// registers and decoding the global configuration into routing controls.
// Assumes hardware status inputs come from logic on I_CORE_CLK.
//
// Behaviour
// - registers at fixed offsets with reset values
// - configuration register resets to 0x302
// - hardware drives read-only low-power state bits
// - usb divider: 00 undivided, 01 halved
// - reference ratio is field plus one, doubled
// - bit 10 picks usb clock source
// - bit 9 picks usb synth input
// - bit 8 picks main synth input
// - clock output selector codes 000 to 110
// - control, status, source status reset values
// - osc control clears only low half
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module ccrb_bank (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ccrb_pkg::CCRB_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic [2:0] I_LOW_POWER_STATE,
    input wire logic [31:0] I_CLOCK_STATUS,
    input wire logic [31:0] I_SOURCE_STATUS,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    output ccrb_pkg::ccrb_cfg_t O_CONFIG,
    output ccrb_pkg::ccrb_route_t O_ROUTE
);

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // one wait state: pready rises in the second access cycle, so read
    // data and the error flag can both come from flops
    wire logic access = I_PSEL & I_PENABLE;
    wire logic done = access & O_PREADY;
    wire logic next_pready = access & ~O_PREADY;
    wire logic [31:0] strb_mask = {{8{I_PSTRB[3]}}, {8{I_PSTRB[2]}},
                                   {8{I_PSTRB[1]}}, {8{I_PSTRB[0]}}};

    logic [ccrb_pkg::CCRB_NUM_REGS-1:0][31:0] regs;
    logic [ccrb_pkg::CCRB_NUM_REGS-1:0][31:0] next_regs;
    logic [ccrb_pkg::CCRB_NUM_REGS-1:0][31:0] hw_value;
    logic [ccrb_pkg::CCRB_NUM_REGS-1:0] hit;
    logic [ccrb_pkg::CCRB_NUM_REGS:0][31:0] rd_chain;

    assign hw_value[ccrb_pkg::IDX_GLOBAL_CLOCK_CONFIG] = {I_LOW_POWER_STATE, 29'h0000_0000};
    assign hw_value[ccrb_pkg::IDX_GLOBAL_CLOCK_STATUS] = I_CLOCK_STATUS;
    assign hw_value[ccrb_pkg::IDX_CLOCK_SOURCE_STATUS] = I_SOURCE_STATUS;
    assign rd_chain[0] = 32'h0000_0000;

    // ----------------------------------------------------------------
    // register entries
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < ccrb_pkg::CCRB_NUM_REGS; i++) begin : g_reg
            wire logic [31:0] wmask;
            wire logic [31:0] sw_value;
            assign hit[i] = (I_PADDR == ccrb_pkg::REG_OFFSET[i]);
            assign wmask = (done & I_PWRITE & hit[i]) ?
                           (ccrb_pkg::REG_WRITE_MASK[i] & strb_mask) : 32'h0000_0000;
            assign sw_value = (regs[i] & ~wmask) | (I_PWDATA & wmask);
            assign next_regs[i] = (sw_value & ~ccrb_pkg::REG_HW_MASK[i]) |
                                  (hw_value[i] & ccrb_pkg::REG_HW_MASK[i]);
            assign rd_chain[i+1] = rd_chain[i] | (hit[i] ? regs[i] : 32'h0000_0000);

            if (i != ccrb_pkg::IDX_GLOBAL_CLOCK_CONFIG &&
                i != ccrb_pkg::IDX_GLOBAL_CLOCK_STATUS &&
                i != ccrb_pkg::IDX_CLOCK_SOURCE_STATUS) begin : g_no_hw
                assign hw_value[i] = 32'h0000_0000;
            end

            if (i == ccrb_pkg::IDX_INTERNAL_OSC_CONTROL) begin : g_half_reset
                // upper half deliberately keeps its value through reset
                always_ff @(posedge I_CORE_CLK) begin
                    if (I_RESET) begin
                        regs[i][ccrb_pkg::OSC_LOW_W-1:0] <= 16'h0000;
                    end else begin
                        regs[i][ccrb_pkg::OSC_LOW_W-1:0] <= next_regs[i][ccrb_pkg::OSC_LOW_W-1:0];
                    end
                end
                always_ff @(posedge I_CORE_CLK) begin
                    regs[i][31:ccrb_pkg::OSC_LOW_W] <= next_regs[i][31:ccrb_pkg::OSC_LOW_W];
                end
            end else begin : g_full_reset
                always_ff @(posedge I_CORE_CLK) begin
                    if (I_RESET) begin
                        regs[i] <= ccrb_pkg::REG_RESET[i];
                    end else begin
                        regs[i] <= next_regs[i];
                    end
                end
            end
        end
    endgenerate

    wire logic any_hit = |hit;

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    // decoded from the next value so outputs change on the same edge
    // as the register itself
    wire logic [31:0] cfg_word = next_regs[ccrb_pkg::IDX_GLOBAL_CLOCK_CONFIG];
    ccrb_pkg::ccrb_cfg_t next_cfg;
    ccrb_pkg::ccrb_route_t next_route;

    assign next_cfg.low_power_state = cfg_word[ccrb_pkg::LPS_LSB +: 3];
    assign next_cfg.usb_divider = cfg_word[ccrb_pkg::USBDIV_LSB +: 2];
    assign next_cfg.reference_divider = cfg_word[ccrb_pkg::REFDIV_LSB +: 5];
    assign next_cfg.usb_source_select = cfg_word[ccrb_pkg::USB_SOURCE_SELECT_BIT];
    assign next_cfg.usb_synth_input_select = cfg_word[ccrb_pkg::USBSYN_BIT];
    assign next_cfg.main_synth_input_select = cfg_word[ccrb_pkg::MAINSYN_BIT];
    assign next_cfg.clock_output_select = cfg_word[ccrb_pkg::CLOCK_OUTPUT_PIN_LSB +: 3];

    assign next_route.reference_ratio = {6'(next_cfg.reference_divider + 5'h01), 1'b0};
    // reserved divider codes yield ratio 0 so the consumer can gate the clock
    assign next_route.usb_ratio = (next_cfg.usb_divider == ccrb_pkg::USBDIV_NONE) ? 2'h1 :
                                  (next_cfg.usb_divider == ccrb_pkg::USBDIV_HALF) ? 2'h2 :
                                  2'h0;
    // code 111 shifts the one out of range: no source routed
    assign next_route.clock_output_route =
        7'(ccrb_pkg::CLOCK_OUTPUT_PIN_ROUTE_ONE << next_cfg.clock_output_select);
    assign next_route.clock_output_div16 =
        (next_cfg.clock_output_select >= ccrb_pkg::CLOCK_OUTPUT_PIN_FIRST_DIV16) &&
        (next_cfg.clock_output_select <= ccrb_pkg::CLOCK_OUTPUT_PIN_LAST_DIV16);

    // ----------------------------------------------------------------
    // reset image of the configuration outputs
    // ----------------------------------------------------------------
    // sliced from the register's own reset word, so the output struct
    // and the register cannot disagree after reset
    wire logic [31:0] cfg_reset_word = ccrb_pkg::REG_RESET[ccrb_pkg::IDX_GLOBAL_CLOCK_CONFIG];
    ccrb_pkg::ccrb_cfg_t reset_cfg;

    assign reset_cfg.low_power_state = cfg_reset_word[ccrb_pkg::LPS_LSB +: 3];
    assign reset_cfg.usb_divider = cfg_reset_word[ccrb_pkg::USBDIV_LSB +: 2];
    assign reset_cfg.reference_divider = cfg_reset_word[ccrb_pkg::REFDIV_LSB +: 5];
    assign reset_cfg.usb_source_select = cfg_reset_word[ccrb_pkg::USB_SOURCE_SELECT_BIT];
    assign reset_cfg.usb_synth_input_select = cfg_reset_word[ccrb_pkg::USBSYN_BIT];
    assign reset_cfg.main_synth_input_select = cfg_reset_word[ccrb_pkg::MAINSYN_BIT];
    assign reset_cfg.clock_output_select = cfg_reset_word[ccrb_pkg::CLOCK_OUTPUT_PIN_LSB +: 3];

    // ----------------------------------------------------------------
    // output flops
    // ----------------------------------------------------------------
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY <= next_pready;
            O_PRDATA <= (next_pready & ~I_PWRITE) ? rd_chain[ccrb_pkg::CCRB_NUM_REGS] :
                        32'h0000_0000;
            O_PSLVERR <= next_pready & ~any_hit;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            O_CONFIG <= reset_cfg;
            O_ROUTE <= ccrb_pkg::ccrb_route_t'(17'h0000);
        end else begin
            O_CONFIG <= next_cfg;
            O_ROUTE <= next_route;
        end
    end

endmodule

`default_nettype wire

// >>> logic/ccrb_pkg.sv
// Constants and carrier types for the clock configuration register bank.
// Assumes a 32-bit APB slave port with a 12-bit byte address.
package ccrb_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int CCRB_NUM_REGS = 18;
    localparam int CCRB_ADDR_W = 12;

    localparam int IDX_GLOBAL_CLOCK_CONFIG = 0;
    localparam int IDX_GLOBAL_CLOCK_STATUS = 2;
    localparam int IDX_CLOCK_SOURCE_STATUS = 11;
    localparam int IDX_INTERNAL_OSC_CONTROL = 14;

    // entry 0 is the lowest slice
    localparam logic [CCRB_NUM_REGS-1:0][CCRB_ADDR_W-1:0] REG_OFFSET = {
        12'h304, 12'h300, 12'h044, 12'h040, 12'h03C, 12'h038,
        12'h034, 12'h030, 12'h02C, 12'h028, 12'h024, 12'h020,
        12'h01C, 12'h018, 12'h00C, 12'h008, 12'h004, 12'h000
    };

    localparam logic [CCRB_NUM_REGS-1:0][31:0] REG_RESET = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0100_0003, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0028,
        32'h0000_0803, 32'h0000_0302
    };

    // bits software may change
    localparam logic [CCRB_NUM_REGS-1:0][31:0] REG_WRITE_MASK = {
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
        32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000,
        32'hFFFF_FFFF, 32'h00C0_FF07
    };

    // bits the hardware drives every cycle
    localparam logic [CCRB_NUM_REGS-1:0][31:0] REG_HW_MASK = {
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hFFFF_FFFF,
        32'h0000_0000, 32'hE000_0000
    };

    // ----------------------------------------------------------------
    // configuration register fields
    // ----------------------------------------------------------------
    localparam int LPS_LSB = 29;
    localparam int USBDIV_LSB = 22;
    localparam int REFDIV_LSB = 11;
    localparam int USB_SOURCE_SELECT_BIT = 10;
    localparam int USBSYN_BIT = 9;
    localparam int MAINSYN_BIT = 8;
    localparam int CLOCK_OUTPUT_PIN_LSB = 0;

    localparam logic [1:0] USBDIV_NONE = 2'h0;
    localparam logic [1:0] USBDIV_HALF = 2'h1;
    localparam logic [2:0] CLOCK_OUTPUT_PIN_FIRST_DIV16 = 3'h1;
    localparam logic [2:0] CLOCK_OUTPUT_PIN_LAST_DIV16 = 3'h4;
    localparam logic [6:0] CLOCK_OUTPUT_PIN_ROUTE_ONE = 7'h01;
    localparam int OSC_LOW_W = 16;

    typedef struct packed {
        logic [2:0] low_power_state;
        logic [1:0] usb_divider;
        logic [4:0] reference_divider;
        logic usb_source_select;
        logic usb_synth_input_select;
        logic main_synth_input_select;
        logic [2:0] clock_output_select;
    } ccrb_cfg_t;

    typedef struct packed {
        logic [6:0] reference_ratio;
        logic [1:0] usb_ratio;
        logic [6:0] clock_output_route;
        logic clock_output_div16;
    } ccrb_route_t;

endpackage

// >>> testbench/ccrb_checker.sv
// Port assertions for the clock configuration register bank.
// Assumes it is bound to ccrb_bank, one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module ccrb_checker (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [ccrb_pkg::CCRB_ADDR_W-1:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    input wire logic [2:0] I_LOW_POWER_STATE,
    input wire logic [31:0] I_CLOCK_STATUS,
    input wire logic [31:0] I_SOURCE_STATUS,
    input wire logic O_PREADY,
    input wire logic [31:0] O_PRDATA,
    input wire logic O_PSLVERR,
    input wire ccrb_pkg::ccrb_cfg_t O_CONFIG,
    input wire ccrb_pkg::ccrb_route_t O_ROUTE
);
    // ----
    // checks
    // ----
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RESET);
    property p_wait; I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY ##1 !O_PREADY; endproperty
    a_wait: assert property (p_wait) else $error("ready timing");
    property p_err; O_PSLVERR |-> O_PREADY && O_PRDATA == 32'h0; endproperty
    a_err: assert property (p_err) else $error("bad error answer");
    property p_lps; 1'h1 |=> O_CONFIG.low_power_state == $past(I_LOW_POWER_STATE); endproperty
    a_lps: assert property (p_lps) else $error("power state");
    property p_rsv; O_PREADY && !I_PWRITE && I_PADDR == 12'h000 |->
        (O_PRDATA & 32'h1F3F_00F8) == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits");
    // decode compared only once the field has settled, so a one-cycle lag is allowed
    property p_ref; !$past(I_RESET) && $stable(O_CONFIG.reference_divider) |->
        O_ROUTE.reference_ratio == (7'(O_CONFIG.reference_divider) + 7'h01) << 1; endproperty
    a_ref: assert property (p_ref) else $error("reference ratio");
    property p_usb; !$past(I_RESET) && $stable(O_CONFIG.usb_divider) |-> O_ROUTE.usb_ratio ==
        (O_CONFIG.usb_divider == 2'h0 ? 2'h1 : O_CONFIG.usb_divider == 2'h1 ? 2'h2 : 2'h0);
    endproperty
    a_usb: assert property (p_usb) else $error("usb ratio");
    property p_out; !$past(I_RESET) && $stable(O_CONFIG.clock_output_select) |->
        O_ROUTE.clock_output_route == (O_CONFIG.clock_output_select == 3'h7 ? 7'h00 :
        7'h01 << O_CONFIG.clock_output_select) && O_ROUTE.clock_output_div16 ==
        (O_CONFIG.clock_output_select inside {[3'h1:3'h4]}); endproperty
    a_out: assert property (p_out) else $error("output route");
    property p_src; I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h000 &&
        I_PSTRB[1] |=> {O_CONFIG.usb_source_select, O_CONFIG.usb_synth_input_select,
        O_CONFIG.main_synth_input_select} == $past(I_PWDATA[10:8]); endproperty
    a_src: assert property (p_src) else $error("source selects");
    property p_rst; $past(I_RESET) |-> {O_CONFIG.usb_divider, O_CONFIG.reference_divider,
        O_CONFIG.usb_source_select, O_CONFIG.usb_synth_input_select,
        O_CONFIG.main_synth_input_select, O_CONFIG.clock_output_select} == 13'h001A; endproperty
    a_rst: assert property (p_rst) else $error("config reset image");
    property p_fld; I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PADDR == 12'h000 &&
        I_PSTRB[0] && I_PSTRB[2] |=> {O_CONFIG.usb_divider, O_CONFIG.clock_output_select} ==
        {$past(I_PWDATA[23:22]), $past(I_PWDATA[2:0])}; endproperty
    a_fld: assert property (p_fld) else $error("divider and output fields");
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench: APB traffic checked against a register model.
// Assumes ccrb_pkg and ccrb_checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ----
    // stimulus and scoreboard
    // ----
    logic I_CORE_CLK = 1'h0, I_RESET = 1'h1, I_PSEL = 1'h0, I_PENABLE = 1'h0, I_PWRITE = 1'h0;
    logic [11:0] I_PADDR = 12'h0;
    logic [31:0] I_PWDATA = 32'h0, I_CLOCK_STATUS = 32'h0, I_SOURCE_STATUS = 32'h0;
    logic [3:0] I_PSTRB = 4'h0;
    logic [2:0] I_LOW_POWER_STATE = 3'h0;
    logic O_PREADY, O_PSLVERR;
    logic [31:0] O_PRDATA;
    ccrb_pkg::ccrb_cfg_t O_CONFIG;
    ccrb_pkg::ccrb_route_t O_ROUTE;
    logic [32:0] exp_q[$], msk_q[$];
    logic [31:0] mdl[18], vis[18];
    int err_count = 0, checked = 0, cycles = 0, seed = 32'h288c;
    ccrb_bank u_ccrb_bank (.I_CORE_CLK, .I_RESET, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
        .I_PWDATA, .I_PSTRB, .I_LOW_POWER_STATE, .I_CLOCK_STATUS, .I_SOURCE_STATUS,
        .O_PREADY, .O_PRDATA, .O_PSLVERR, .O_CONFIG, .O_ROUTE);
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        checked++;
        if (seen !== want) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // called at a rising edge; leaves select up so the next setup can follow at once
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s);
        int i;
        logic [31:0] m, e, cs, ss;
        logic [2:0] lp;
        lp = 3'($unsigned($random(seed)) % 5);
        cs = $random(seed);
        ss = $random(seed);
        i = 0;
        while (i < 18 && ccrb_pkg::REG_OFFSET[i] !== a) i++;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        e = (i < 18) ? mdl[i] : 32'h0;
        if (i == ccrb_pkg::IDX_GLOBAL_CLOCK_STATUS) e = cs;
        if (i == ccrb_pkg::IDX_CLOCK_SOURCE_STATUS) e = ss;
        if (i == ccrb_pkg::IDX_GLOBAL_CLOCK_CONFIG) e[31:29] = lp;
        exp_q.push_back({i == 18, w ? 32'h0 : e});
        msk_q.push_back({1'h1, (w || i == 18) ? 32'hFFFF_FFFF : vis[i]});
        if (w && i < 18) begin
            m &= ccrb_pkg::REG_WRITE_MASK[i];
            mdl[i] = (mdl[i] & ~m) | (d & m);
            vis[i] |= m;
        end
        I_LOW_POWER_STATE <= lp;
        I_CLOCK_STATUS <= cs;
        I_SOURCE_STATUS <= ss;
        I_PSEL <= 1'h1;
        I_PENABLE <= 1'h0;
        I_PWRITE <= w;
        I_PADDR <= a;
        I_PWDATA <= d;
        I_PSTRB <= s;
        @(posedge I_CORE_CLK);
        I_PENABLE <= 1'h1;
        do @(posedge I_CORE_CLK); while (O_PREADY !== 1'h1);
    endtask
    always @(negedge I_CORE_CLK) begin
        logic [32:0] mk;
        cycles++;
        if (O_PREADY === 1'h1) begin
            mk = msk_q.pop_front();
            check({O_PSLVERR, O_PRDATA} & mk, exp_q.pop_front() & mk);
        end
        if (cycles == 3000) begin
            err_count++;
            report_and_stop();
        end
    end
    initial begin
        forever #5 I_CORE_CLK = ~I_CORE_CLK;
    end
    initial begin
        logic [11:0] a;
        logic [31:0] d;
        logic [3:0] s;
        logic [11:0] bad[5] = '{12'h010, 12'h014, 12'h002, 12'h308, 12'hFFC};
        foreach (mdl[i]) begin
            mdl[i] = ccrb_pkg::REG_RESET[i];
            vis[i] = (i == ccrb_pkg::IDX_INTERNAL_OSC_CONTROL) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
        end
        repeat (10) @(posedge I_CORE_CLK);
        I_RESET <= 1'h0;
        for (int i = 0; i < 18; i++) begin
            xfer(1'h0, ccrb_pkg::REG_OFFSET[i], 32'h0, 4'h0);
        end
        // later passes sweep every usb divider and output code at the config word, reference divider at 0 and 31 only
        for (int k = 0; k < 84; k++) begin
            d = $random(seed);
            s = 4'($random(seed));
            a = ccrb_pkg::REG_OFFSET[k % 18];
            if (k >= 36) begin
                a = 12'h000;
                s = 4'hF;
                d[2:0] = k[2:0];
                d[23:22] = k[4:3];
                d[15:11] = {5{k[0]}};
            end
            xfer(1'h1, a, d, s);
            xfer(1'h0, a, 32'h0, 4'h0);
        end
        foreach (bad[j]) begin
            xfer(1'h1, bad[j], 32'hFFFF_FFFF, 4'hF);
            xfer(1'h0, bad[j], 32'h0, 4'h0);
            xfer(1'h0, 12'h000, 32'h0, 4'h0);
        end
        I_PSEL <= 1'h0;
        I_PENABLE <= 1'h0;
        repeat (3) @(posedge I_CORE_CLK);
        report_and_stop();
    end
endmodule
bind ccrb_bank ccrb_checker u_ccrb_checker (.I_CORE_CLK, .I_RESET, .I_PSEL, .I_PENABLE,
    .I_PWRITE, .I_PADDR, .I_PWDATA, .I_PSTRB, .I_LOW_POWER_STATE, .I_CLOCK_STATUS,
    .I_SOURCE_STATUS, .O_PREADY, .O_PRDATA, .O_PSLVERR, .O_CONFIG, .O_ROUTE);
`default_nettype wire
